// ### core/interrupt_priority_arbiter.sv
// Interrupt priority arbitration and segment paging control
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module interrupt_priority_arbiter (
	input  wire logic        CORE_CLK,     // Core clock
	input  wire logic        RESET,        // Async reset, high
	input  wire logic [7:0]  REG_ADDR,     // Register address
	input  wire logic [7:0]  REG_WDATA,    // Register write data
	input  wire logic        REG_WR,       // Write strobe
	input  wire logic        REG_RD,       // Read strobe
	output logic      [7:0]  REG_RDATA,    // Read data, next cycle
	input  wire logic [10:0] IRQ_REQ,      // Channel interrupt requests
	input  wire logic [10:0] DMA_REQ,      // Channel DMA requests
	input  wire logic        WDT_TOP_REQ,  // Watchdog top level request
	input  wire logic        NMI_PIN,      // External top level pin
	input  wire logic        ARB_STROBE,   // Arbitration phase pulse
	input  wire logic [15:0] PC_IN,        // Current program counter
	input  wire logic [7:0]  FLAGS_IN,     // Current flags word
	input  wire logic        IRET_REQ,     // Return from interrupt
	input  wire logic        FAR_SEG_WR,   // Far call or jump load
	input  wire logic [7:0]  FAR_SEG_VAL,  // Segment for far load
	output logic             IRQ_ACK,      // Interrupt acknowledged
	output logic      [3:0]  ACK_CHAN,     // Acknowledged channel
	output logic             DMA_GRANT,    // DMA request granted
	output logic      [3:0]  DMA_CHAN,     // Granted DMA channel
	output logic             STK_PUSH,     // Stack push strobe
	output logic      [7:0]  STK_WDATA,    // Stack push byte
	output logic             STK_POP,      // Stack pop strobe
	input  wire logic [7:0]  STK_RDATA,    // Popped byte, next cycle
	output logic             VEC_REQ,      // Vector fetch strobe
	output logic      [3:0]  VEC_INDEX,    // Vector slot
	input  wire logic [15:0] VEC_DATA,     // Vector, next cycle
	output logic             PC_LOAD,      // Load program counter
	output logic      [15:0] PC_VALUE,     // New program counter
	output logic             FLAGS_LOAD,   // Load flags word
	output logic      [7:0]  FLAGS_VALUE,  // New flags word
	output logic      [7:0]  CODE_SEG,     // Segment in use for code
	output logic             BUSY          // Entry or return running
);

	typedef struct packed {
		irq_arb_pkg::state_t              st;
		irq_arb_pkg::pend_t               pend;
		logic [2:0]                       cpu_priority_level;
		logic                             global_irq_enable;
		logic                             arbitration_mode_select;
		logic                             top_level_maskable_irq;
		logic                             top_src_pin;
		logic                             segment_save_enable;
		logic [7:0]                       interrupt_segment_reg;
		logic [7:0]                       code_segment_reg;
		logic [10:0][2:0]                 channel_priority_level;
		logic [3:0]                       ack_ch;
		logic                             top_active;
		logic                             far_blocked;
		logic [3:0]                       legacy_depth;
		logic [15:0]                      pc_save;
		logic [7:0]                       flags_word;
		logic [7:0]                       rdata;
		logic                             ack_v;
		logic                             dma_v;
		logic [3:0]                       dma_ch;
		logic [7:0]                       push_d;
		logic [15:0]                      pc_ld;
		logic                             pc_ld_v;
		logic [7:0]                       fl_ld;
		logic                             fl_ld_v;
		logic [7:0]                       cseg;
		logic [2:0]                       pin_s;
		logic                             pin_lvl;
	} arb_state_t;

	arb_state_t r;
	arb_state_t n;

	logic [irq_arb_pkg::NREQ-1:0]                    arb_req;
	logic [irq_arb_pkg::NREQ-1:0][irq_arb_pkg::PRL_W-1:0] arb_lvl;
	logic                                            win_v;
	logic [irq_arb_pkg::IDX_W-1:0]                   win_idx;
	logic [irq_arb_pkg::PRL_W-1:0]                   win_lvl;
	logic                                            win_irq;
	logic [3:0]                                      win_ch;
	logic                                            top_req;
	logic                                            top_ok;

	// Priority register hit and channel index for an address
	function automatic logic [4:0] prl_decode(input logic [7:0] a);
		logic [7:0] off;
		off = a - irq_arb_pkg::A_PRL_BASE;
		if (a >= irq_arb_pkg::A_PRL_BASE && off < 8'(irq_arb_pkg::NCH))
			prl_decode = {1'b1, off[3:0]};
		else
			prl_decode = 5'h00;
	endfunction

	// DMA at even slot, interrupt at odd slot of the same channel
	genvar g;
	generate
		for (g = 0; g < irq_arb_pkg::NCH; g++)
		begin : g_req
			assign arb_req[2*g]   = DMA_REQ[g];
			assign arb_req[2*g+1] = IRQ_REQ[g];
			assign arb_lvl[2*g]   = r.channel_priority_level[g];
			assign arb_lvl[2*g+1] = r.channel_priority_level[g];
		end
	endgenerate

	priority_select u_select (
		.req     (arb_req),
		.lvl     (arb_lvl),
		.win_v   (win_v),
		.win_idx (win_idx),
		.win_lvl (win_lvl)
	);

	assign win_irq = win_idx[0];
	assign win_ch  = win_idx[4:1];

	// Top level source and its mask
	assign top_req = r.top_src_pin ? r.pin_lvl : WDT_TOP_REQ;
	assign top_ok  = top_req && !r.top_active
		&& (!r.top_level_maskable_irq || r.global_irq_enable);

	always_comb
	begin
		logic [4:0] hit;
		hit = prl_decode(REG_ADDR);
		n = r;
		n.ack_v   = 1'b0;
		n.dma_v   = 1'b0;
		n.pc_ld_v = 1'b0;
		n.fl_ld_v = 1'b0;
		n.rdata   = 8'h00;
		n.pend    = irq_arb_pkg::PEND_NONE;

		// Pin synchroniser, level taken once stages two and three agree
		n.pin_s = {r.pin_s[1:0], NMI_PIN};
		if (r.pin_s[1] == r.pin_s[2])
			n.pin_lvl = r.pin_s[2];

		// Register read
		if (REG_RD)
		begin
			if (hit[4])
				n.rdata = {5'h00, r.channel_priority_level[hit[3:0]]};
			else
			begin
				case (REG_ADDR)
					irq_arb_pkg::A_CENTRAL_IRQ_CONTROL_REG: n.rdata = {r.top_src_pin,
						r.top_level_maskable_irq, r.arbitration_mode_select,
						r.global_irq_enable, 1'b0, r.cpu_priority_level};
					irq_arb_pkg::A_EXTENDED_MODE_REG_TWO: n.rdata = {7'h00,
						r.segment_save_enable};
					irq_arb_pkg::A_ISEG: n.rdata = r.interrupt_segment_reg;
					irq_arb_pkg::A_CSEG: n.rdata = r.code_segment_reg;
					irq_arb_pkg::A_STAT: n.rdata = {2'h0, r.far_blocked,
						r.top_active, r.ack_ch};
					default: n.rdata = 8'h00;
				endcase
			end
		end

		// Register write, hardware updates below take precedence
		if (REG_WR)
		begin
			if (hit[4])
				n.channel_priority_level[hit[3:0]] = REG_WDATA[2:0];
			else
			begin
				case (REG_ADDR)
					irq_arb_pkg::A_CENTRAL_IRQ_CONTROL_REG:
					begin
						n.cpu_priority_level = REG_WDATA[
							irq_arb_pkg::CENTRAL_IRQ_CONTROL_REG_CPL_LSB +: 3];
						n.global_irq_enable = REG_WDATA[irq_arb_pkg::CENTRAL_IRQ_CONTROL_REG_IEN];
						n.arbitration_mode_select =
							REG_WDATA[irq_arb_pkg::CENTRAL_IRQ_CONTROL_REG_IAM];
						n.top_level_maskable_irq =
							REG_WDATA[irq_arb_pkg::CENTRAL_IRQ_CONTROL_REG_TLMASK];
						n.top_src_pin = REG_WDATA[irq_arb_pkg::CENTRAL_IRQ_CONTROL_REG_TLSRC];
					end
					irq_arb_pkg::A_EXTENDED_MODE_REG_TWO: n.segment_save_enable =
						REG_WDATA[irq_arb_pkg::EXTENDED_MODE_REG_TWO_SEGSAVE];
					irq_arb_pkg::A_ISEG: n.interrupt_segment_reg = REG_WDATA;
					irq_arb_pkg::A_CSEG: n.code_segment_reg = REG_WDATA;
					irq_arb_pkg::A_STAT:
						if (REG_WDATA[irq_arb_pkg::STAT_BLOCKED])
							n.far_blocked = 1'b0;
					default: ;
				endcase
			end
		end

		// Far segment loads; legacy routines stay in the interrupt segment
		if (FAR_SEG_WR)
		begin
			if (r.legacy_depth != '0)
				n.far_blocked = 1'b1;
			else
				n.code_segment_reg = FAR_SEG_VAL;
		end

		// Capture of a byte popped in the previous cycle
		case (r.pend)
			irq_arb_pkg::PEND_FLG:
			begin
				n.fl_ld   = STK_RDATA;
				n.fl_ld_v = 1'b1;
			end
			irq_arb_pkg::PEND_CSR: n.code_segment_reg = STK_RDATA;
			irq_arb_pkg::PEND_PCH: n.pc_save[15:8] = STK_RDATA;
			default: ;
		endcase

		case (r.st)
			irq_arb_pkg::S_IDLE:
			begin
				if (IRET_REQ)
					n.st = irq_arb_pkg::S_POP_FLG;
				else if (ARB_STROBE)
				begin
					if (top_ok)
					begin
						n.ack_ch     = irq_arb_pkg::VEC_TOP;
						n.top_active = 1'b1;
					end
					else if (win_v && !win_irq)
					begin
						n.dma_v  = 1'b1;
						n.dma_ch = win_ch;
					end
					// Strict compare also rejects level 7 and same level
					else if (win_v && r.global_irq_enable && !r.top_active
						&& win_lvl < r.cpu_priority_level)
						n.ack_ch = win_ch;
					if (top_ok || (win_v && win_irq && r.global_irq_enable
						&& !r.top_active && win_lvl < r.cpu_priority_level))
					begin
						// CPU priority is left as it stands
						n.ack_v             = 1'b1;
						n.global_irq_enable = 1'b0;
						n.pc_save           = PC_IN;
						n.flags_word        = FLAGS_IN;
						n.push_d            = PC_IN[7:0];
						n.st                = irq_arb_pkg::S_PUSH_PCL;
					end
				end
			end
			irq_arb_pkg::S_PUSH_PCL:
			begin
				n.push_d = r.pc_save[15:8];
				n.st     = irq_arb_pkg::S_PUSH_PCH;
			end
			irq_arb_pkg::S_PUSH_PCH:
			begin
				if (r.segment_save_enable)
				begin
					n.push_d = r.code_segment_reg;
					n.st     = irq_arb_pkg::S_PUSH_CSR;
				end
				else
				begin
					n.push_d = r.flags_word;
					n.st     = irq_arb_pkg::S_PUSH_FLG;
				end
			end
			irq_arb_pkg::S_PUSH_CSR:
			begin
				n.push_d = r.flags_word;
				n.st     = irq_arb_pkg::S_PUSH_FLG;
			end
			irq_arb_pkg::S_PUSH_FLG: n.st = irq_arb_pkg::S_VEC_RD;
			irq_arb_pkg::S_VEC_RD:   n.st = irq_arb_pkg::S_VEC_WAIT;
			irq_arb_pkg::S_VEC_WAIT:
			begin
				n.pc_ld   = VEC_DATA;
				n.pc_ld_v = 1'b1;
				if (r.segment_save_enable)
					n.code_segment_reg = r.interrupt_segment_reg;
				else
					n.legacy_depth = r.legacy_depth + irq_arb_pkg::DEPTH_ONE;
				n.st = irq_arb_pkg::S_IDLE;
			end
			irq_arb_pkg::S_POP_FLG:
			begin
				n.pend = irq_arb_pkg::PEND_FLG;
				n.st   = r.segment_save_enable ? irq_arb_pkg::S_POP_CSR
					: irq_arb_pkg::S_POP_PCH;
			end
			irq_arb_pkg::S_POP_CSR:
			begin
				n.pend = irq_arb_pkg::PEND_CSR;
				n.st   = irq_arb_pkg::S_POP_PCH;
			end
			irq_arb_pkg::S_POP_PCH:
			begin
				n.pend = irq_arb_pkg::PEND_PCH;
				n.st   = irq_arb_pkg::S_POP_PCL;
			end
			irq_arb_pkg::S_POP_PCL:
			begin
				n.pend = irq_arb_pkg::PEND_PCL;
				n.st   = irq_arb_pkg::S_POP_END;
			end
			irq_arb_pkg::S_POP_END:
			begin
				n.pc_ld             = {r.pc_save[15:8], STK_RDATA};
				n.pc_ld_v           = 1'b1;
				n.global_irq_enable = 1'b1;
				n.top_active        = 1'b0;
				if (!r.segment_save_enable && r.legacy_depth != '0)
					n.legacy_depth = r.legacy_depth - irq_arb_pkg::DEPTH_ONE;
				n.st = irq_arb_pkg::S_IDLE;
			end
			default: n.st = irq_arb_pkg::S_IDLE;
		endcase

		// Legacy routines run from the interrupt segment
		n.cseg = (n.legacy_depth != '0) ? n.interrupt_segment_reg
			: n.code_segment_reg;
	end

	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			r                          <= '0;
			r.st                       <= irq_arb_pkg::S_IDLE;
			r.pend                     <= irq_arb_pkg::PEND_NONE;
			r.cpu_priority_level       <= irq_arb_pkg::CPL_RESET;
			r.channel_priority_level   <= {irq_arb_pkg::NCH{
				irq_arb_pkg::PRL_LOWEST}};
		end
		else
			r <= n;
	end

	assign REG_RDATA   = r.rdata;
	assign IRQ_ACK     = r.ack_v;
	assign ACK_CHAN    = r.ack_ch;
	assign DMA_GRANT   = r.dma_v;
	assign DMA_CHAN    = r.dma_ch;
	assign STK_WDATA   = r.push_d;
	assign PC_LOAD     = r.pc_ld_v;
	assign PC_VALUE    = r.pc_ld;
	assign FLAGS_LOAD  = r.fl_ld_v;
	assign FLAGS_VALUE = r.fl_ld;
	assign CODE_SEG    = r.cseg;
	assign VEC_INDEX   = r.ack_ch;

	assign STK_PUSH = (r.st == irq_arb_pkg::S_PUSH_PCL)
		|| (r.st == irq_arb_pkg::S_PUSH_PCH)
		|| (r.st == irq_arb_pkg::S_PUSH_CSR)
		|| (r.st == irq_arb_pkg::S_PUSH_FLG);
	assign STK_POP = (r.st == irq_arb_pkg::S_POP_FLG)
		|| (r.st == irq_arb_pkg::S_POP_CSR)
		|| (r.st == irq_arb_pkg::S_POP_PCH)
		|| (r.st == irq_arb_pkg::S_POP_PCL);
	assign VEC_REQ = (r.st == irq_arb_pkg::S_VEC_RD);
	assign BUSY    = (r.st != irq_arb_pkg::S_IDLE);

endmodule

// ### core/irq_arb_pkg.sv
// Constants and types shared by the interrupt priority arbiter
package irq_arb_pkg;

	localparam int NCH   = 11;
	localparam int NREQ  = 22;
	localparam int CH_W  = 4;
	localparam int IDX_W = 5;
	localparam int PRL_W = 3;
	localparam int DW    = 8;
	localparam int AW    = 8;
	localparam int PCW   = 16;
	localparam int DEP_W = 4;

	// Daisy chain positions, index 0 is the highest position
	localparam logic [CH_W-1:0] CH_A0_WDT  = 4'h0;
	localparam logic [CH_W-1:0] CH_A1_STIM = 4'h1;
	localparam logic [CH_W-1:0] CH_B0_EFT0 = 4'h2;
	localparam logic [CH_W-1:0] CH_B1_EFT1 = 4'h3;
	localparam logic [CH_W-1:0] CH_C0_FLSH = 4'h4;
	localparam logic [CH_W-1:0] CH_C1_SPI  = 4'h5;
	localparam logic [CH_W-1:0] CH_D0_CLK  = 4'h6;
	localparam logic [CH_W-1:0] CH_D1_WAKE = 4'h7;
	localparam logic [CH_W-1:0] CH_MFT0    = 4'h8;
	localparam logic [CH_W-1:0] CH_E0      = 4'h9;
	localparam logic [CH_W-1:0] CH_E1      = 4'hA;
	localparam logic [CH_W-1:0] VEC_TOP    = 4'hF;

	localparam logic [PRL_W-1:0] PRL_LOWEST = 3'h7;
	localparam logic [PRL_W-1:0] CPL_RESET  = 3'h7;
	localparam logic [DEP_W-1:0] DEPTH_ONE  = 4'h1;

	// Register offsets
	localparam logic [AW-1:0] A_CENTRAL_IRQ_CONTROL_REG     = 8'h00;
	localparam logic [AW-1:0] A_EXTENDED_MODE_REG_TWO     = 8'h01;
	localparam logic [AW-1:0] A_ISEG     = 8'h02;
	localparam logic [AW-1:0] A_CSEG     = 8'h03;
	localparam logic [AW-1:0] A_STAT     = 8'h04;
	localparam logic [AW-1:0] A_PRL_BASE = 8'h10;

	// Field positions
	localparam int CENTRAL_IRQ_CONTROL_REG_CPL_LSB = 0;
	localparam int CENTRAL_IRQ_CONTROL_REG_IEN     = 4;
	localparam int CENTRAL_IRQ_CONTROL_REG_IAM     = 5;
	localparam int CENTRAL_IRQ_CONTROL_REG_TLMASK  = 6;
	localparam int CENTRAL_IRQ_CONTROL_REG_TLSRC   = 7;
	localparam int EXTENDED_MODE_REG_TWO_SEGSAVE = 0;
	localparam int STAT_TLACT   = 4;
	localparam int STAT_BLOCKED = 5;

	typedef enum logic [11:0] {
		S_IDLE     = 12'h001,
		S_PUSH_PCL = 12'h002,
		S_PUSH_PCH = 12'h004,
		S_PUSH_CSR = 12'h008,
		S_PUSH_FLG = 12'h010,
		S_VEC_RD   = 12'h020,
		S_VEC_WAIT = 12'h040,
		S_POP_FLG  = 12'h080,
		S_POP_CSR  = 12'h100,
		S_POP_PCH  = 12'h200,
		S_POP_PCL  = 12'h400,
		S_POP_END  = 12'h800
	} state_t;

	typedef enum logic [2:0] {
		PEND_NONE = 3'h0,
		PEND_FLG  = 3'h1,
		PEND_CSR  = 3'h2,
		PEND_PCH  = 3'h3,
		PEND_PCL  = 3'h4
	} pend_t;

endpackage

// ### core/priority_select.sv
// Priority comparator with fixed daisy chain tie break
`timescale 1ns/1ns
module priority_select (
	input  wire logic [irq_arb_pkg::NREQ-1:0]                    req,   // Requests
	input  wire logic [irq_arb_pkg::NREQ-1:0][irq_arb_pkg::PRL_W-1:0] lvl, // Levels
	output logic                                                 win_v, // Any request
	output logic [irq_arb_pkg::IDX_W-1:0]                        win_idx, // Winner
	output logic [irq_arb_pkg::PRL_W-1:0]                        win_lvl  // Its level
);

	always_comb
	begin
		win_v   = 1'b0;
		win_idx = '0;
		win_lvl = irq_arb_pkg::PRL_LOWEST;
		// Walk downward so the highest chain position wins a tie
		for (int i = irq_arb_pkg::NREQ - 1; i >= 0; i--)
		begin
			if (req[i] && (!win_v || lvl[i] <= win_lvl))
			begin
				win_v   = 1'b1;
				win_idx = i[irq_arb_pkg::IDX_W-1:0];
				win_lvl = lvl[i];
			end
		end
	end

endmodule

// ### verif/partner_cpu.sv
// Stack memory and vector table model for the core side
`timescale 1ns/1ns
module partner_cpu (
	input  wire logic        clk,   // Core clock
	input  wire logic        rst,   // Reset, high
	input  wire logic        push,  // Push strobe
	input  wire logic [7:0]  wdata, // Pushed byte
	input  wire logic        pop,   // Pop strobe
	output logic      [7:0]  rdata, // Popped byte
	input  wire logic        vreq,  // Vector fetch
	input  wire logic [3:0]  vidx,  // Vector slot
	output logic      [15:0] vdata  // Vector word
);
	logic [7:0] mem [16];
	logic [3:0] sp = 4'h0;
	initial rdata = 8'h00;
	initial vdata = 16'h0000;
	// Answers stand one cycle only, then flip to expose stale use
	always @(posedge clk)
	begin
		rdata <= ~rdata;
		vdata <= ~vdata;
		if (rst)
			sp <= 4'h0;
		else if (push)
		begin
			mem[sp] <= wdata;
			sp <= sp + 4'h1;
		end
		else if (pop)
		begin
			rdata <= mem[sp - 4'h1];
			sp <= sp - 4'h1;
		end
		if (vreq)
			vdata <= {12'h800, vidx};
	end
endmodule

// ### verif/arb_sva.sv
// Port-level assertions for the interrupt priority arbiter
`timescale 1ns/1ns
module arb_sva (
	input wire logic        CORE_CLK,    // Clock
	input wire logic        RESET,       // Reset
	input wire logic        REG_RD,      // Read strobe
	input wire logic [7:0]  REG_RDATA,   // Read data
	input wire logic        ARB_STROBE,  // Arbitration
	input wire logic [15:0] PC_IN,       // PC
	input wire logic        IRET_REQ,    // Return
	input wire logic        IRQ_ACK,     // Ack
	input wire logic [3:0]  ACK_CHAN,    // Ack channel
	input wire logic        DMA_GRANT,   // Grant
	input wire logic        STK_PUSH,    // Push
	input wire logic [7:0]  STK_WDATA,   // Push byte
	input wire logic        STK_POP,     // Pop
	input wire logic [7:0]  STK_RDATA,   // Pop byte
	input wire logic        VEC_REQ,     // Vector fetch
	input wire logic [3:0]  VEC_INDEX,   // Vector slot
	input wire logic [15:0] VEC_DATA,    // Vector
	input wire logic        PC_LOAD,     // PC load
	input wire logic [15:0] PC_VALUE,    // New PC
	input wire logic        FLAGS_LOAD,  // Flags load
	input wire logic [7:0]  FLAGS_VALUE, // New flags
	input wire logic        BUSY         // Sequence running
);
	logic [15:0] pc_cap;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	always_ff @(posedge CORE_CLK or posedge RESET)
		if (RESET)
			pc_cap <= 16'h0000;
		else if (ARB_STROBE && !BUSY)
			pc_cap <= PC_IN;
	a_ack_from_strobe: assert property (IRQ_ACK |->
		($past(ARB_STROBE) && !$past(BUSY)) ##1 !IRQ_ACK) else $error("ack");
	a_grant_from_strobe: assert property (DMA_GRANT |->
		$past(ARB_STROBE) ##1 !DMA_GRANT) else $error("grant");
	a_single_winner: assert property (!(IRQ_ACK && DMA_GRANT))
		else $error("two winners");
	a_push_pc_first: assert property (IRQ_ACK |->
		(STK_PUSH && STK_WDATA == pc_cap[7:0]) ##1
		(STK_PUSH && STK_WDATA == pc_cap[15:8])) else $error("pc push");
	a_vector_load: assert property (VEC_REQ |->
		VEC_INDEX == ACK_CHAN ##2 (PC_LOAD && PC_VALUE == $past(VEC_DATA)))
		else $error("vector");
	a_entry_bounded: assert property (IRQ_ACK |->
		BUSY[*5] ##[1:2] !BUSY) else $error("entry length");
	a_iret_pops: assert property (IRET_REQ && !BUSY |=> STK_POP && BUSY)
		else $error("iret");
	a_flags_restore: assert property (FLAGS_LOAD |->
		FLAGS_VALUE == $past(STK_RDATA) && $past(STK_POP, 2))
		else $error("flags");
	a_push_pop_apart: assert property (!(STK_PUSH && STK_POP))
		else $error("push and pop");
	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
		else $error("read data idle");
endmodule
bind interrupt_priority_arbiter arb_sva u_sva (.CORE_CLK, .RESET, .REG_RD,
	.REG_RDATA, .ARB_STROBE, .PC_IN, .IRET_REQ, .IRQ_ACK, .ACK_CHAN,
	.DMA_GRANT, .STK_PUSH, .STK_WDATA, .STK_POP, .STK_RDATA, .VEC_REQ,
	.VEC_INDEX, .VEC_DATA, .PC_LOAD, .PC_VALUE, .FLAGS_LOAD, .FLAGS_VALUE,
	.BUSY);

// ### verif/tb.sv
// Self-checking bench for the interrupt priority arbiter
`timescale 1ns/1ns
module tb;
	logic        clk = 1'h0, rst = 1'h1, wr_s = 1'h0, rd_s = 1'h0;
	logic        top = 1'h0, arb = 1'h0, iret = 1'h0, far = 1'h0;
	logic        nmi = 1'h0;
	logic [7:0]  addr = 8'h00, wdat = 8'h00, far_v = 8'h00, rdat, v;
	logic [10:0] irq = 11'h000, dma = 11'h000;
	logic [15:0] pc = 16'h1234, vdata, pc_v;
	logic [7:0]  flg = 8'hA5, stk_wd, stk_rd, fl_v, cseg;
	logic        ack, grant, push, pop, vreq, pc_ld, fl_ld, busy;
	logic [3:0]  ack_ch, dma_ch, vidx;
	int          mismatches = 0, samples_checked = 0, cycles = 0;
	interrupt_priority_arbiter dut (.CORE_CLK(clk), .RESET(rst),
		.REG_ADDR(addr), .REG_WDATA(wdat), .REG_WR(wr_s), .REG_RD(rd_s),
		.REG_RDATA(rdat), .IRQ_REQ(irq), .DMA_REQ(dma), .WDT_TOP_REQ(top),
		.NMI_PIN(nmi), .ARB_STROBE(arb), .PC_IN(pc), .FLAGS_IN(flg),
		.IRET_REQ(iret), .FAR_SEG_WR(far), .FAR_SEG_VAL(far_v),
		.IRQ_ACK(ack), .ACK_CHAN(ack_ch), .DMA_GRANT(grant),
		.DMA_CHAN(dma_ch), .STK_PUSH(push), .STK_WDATA(stk_wd),
		.STK_POP(pop), .STK_RDATA(stk_rd), .VEC_REQ(vreq), .VEC_INDEX(vidx),
		.VEC_DATA(vdata), .PC_LOAD(pc_ld), .PC_VALUE(pc_v),
		.FLAGS_LOAD(fl_ld), .FLAGS_VALUE(fl_v), .CODE_SEG(cseg),
		.BUSY(busy));
	partner_cpu cpu (.clk(clk), .rst(rst), .push(push), .wdata(stk_wd),
		.pop(pop), .rdata(stk_rd), .vreq(vreq), .vidx(vidx), .vdata(vdata));
	initial
		forever #2 clk = ~clk;
	task automatic complete_run();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			complete_run();
		end
	end
	task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr_s <= 1'h1;
		@(posedge clk);
		wr_s <= 1'h0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'h1;
		@(posedge clk);
		rd_s <= 1'h0;
		#1 v = rdat;
	endtask
	task automatic strobe();
		@(posedge clk);
		arb <= 1'h1;
		@(posedge clk);
		arb <= 1'h0;
		#1;
	endtask
	task automatic far_ld(logic [7:0] s);
		@(posedge clk);
		far <= 1'h1;
		far_v <= s;
		@(posedge clk);
		far <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// Entry: ack, byte pushes, vector load, segment in use
	task automatic entry(logic [3:0] ch, int np, logic [7:0] seg);
		int n;
		logic [15:0] pv;
		n = 0;
		pv = 16'h0000;
		strobe();
		check("ack", ack, 1'h1);
		check("ack_chan", ack_ch, ch);
		repeat (10)
		begin
			n += (push === 1'h1);
			if (pc_ld === 1'h1)
				pv = pc_v;
			@(posedge clk);
			#1;
		end
		check("pushes", 16'(n), 16'(np));
		check("vector", pv, {12'h800, ch});
		check("busy", busy, 1'h0);
		check("code_seg", cseg, seg);
	endtask
	task automatic leave(logic [7:0] seg);
		logic [15:0] pv;
		logic [7:0]  fv;
		pv = 16'h0000;
		fv = 8'h00;
		@(posedge clk);
		iret <= 1'h1;
		@(posedge clk);
		iret <= 1'h0;
		repeat (8)
		begin
			#1;
			if (pc_ld === 1'h1)
				pv = pc_v;
			if (fl_ld === 1'h1)
				fv = fl_v;
			@(posedge clk);
		end
		#1;
		check("ret_pc", pv, pc);
		check("ret_flags", fv, flg);
		check("ret_seg", cseg, seg);
	endtask
	task automatic t_reset();
		rd(8'h00);
		check("central_irq_control_reg", v, 8'h07);
		rd(8'h01);
		check("extended_mode_reg_two", v, 8'h00);
		rd(8'h1A);
		check("prl", v, 8'h07);
		rd(8'h30);
		check("unmapped", v, 8'h00);
		wr(8'h02, 8'h44);
		wr(8'h03, 8'h33);
		rd(8'h02);
		check("iseg", v, 8'h44);
		rd(8'h03);
		check("cseg", v, 8'h33);
		$display("t_reset done");
	endtask
	task automatic t_levels();
		irq <= 11'h7FF;
		wr(8'h00, 8'h17);
		strobe();
		check("polled", ack, 1'h0);
		irq <= 11'h004;
		wr(8'h12, 8'h03);
		wr(8'h00, 8'h13);
		strobe();
		check("equal_cpl", ack, 1'h0);
		wr(8'h00, 8'h14);
		entry(4'h2, 3, 8'h44);
		irq <= 11'h000;
		leave(8'h33);
		$display("t_levels done");
	endtask
	task automatic t_chain();
		for (int i = 0; i < 11; i++)
			wr(8'(8'h10 + i), 8'h02);
		wr(8'h00, 8'h17);
		for (int i = 0; i < 10; i++)
		begin
			irq <= 11'h003 << i;
			entry(4'(i), 3, 8'h44);
			irq <= 11'h000;
			leave(8'h33);
		end
		$display("t_chain done");
	endtask
	task automatic t_legacy();
		irq <= 11'h010;
		entry(4'h4, 3, 8'h44);
		irq <= 11'h000;
		rd(8'h00);
		check("ien_clr", v[4], 1'h0);
		far_ld(8'h5A);
		check("seg_kept", cseg, 8'h44);
		rd(8'h04);
		check("blocked", v[5], 1'h1);
		leave(8'h33);
		rd(8'h00);
		check("ien_set", v[4], 1'h1);
		wr(8'h04, 8'h20);
		rd(8'h04);
		check("unblocked", v, 8'h04);
		$display("t_legacy done");
	endtask
	task automatic t_ext();
		wr(8'h01, 8'h01);
		irq <= 11'h010;
		entry(4'h4, 4, 8'h44);
		irq <= 11'h000;
		check("stk_seg", cpu.mem[2], 8'h33);
		check("stk_flg", cpu.mem[3], flg);
		far_ld(8'h5A);
		check("far_seg", cseg, 8'h5A);
		leave(8'h33);
		$display("t_ext done");
	endtask
	task automatic t_top();
		// Watchdog maskable, watchdog non-maskable, then the pin source
		for (int m = 0; m < 3; m++)
		begin
			wr(8'h00, m == 0 ? 8'h57 : (m == 1 ? 8'h07 : 8'h87));
			top <= (m < 2);
			nmi <= (m == 2);
			irq <= 11'h001;
			// Let the pin pass its synchroniser
			repeat (4) @(posedge clk);
			entry(4'hF, 4, 8'h44);
			// Enable on inside the top routine, still no nesting
			wr(8'h00, m == 2 ? 8'h97 : 8'h17);
			strobe();
			check("top_hold", ack, 1'h0);
			top <= 1'h0;
			nmi <= 1'h0;
			irq <= 11'h000;
			leave(8'h33);
		end
		$display("t_top done");
	endtask
	task automatic t_dma();
		wr(8'h00, 8'h23);
		dma <= 11'h040;
		strobe();
		check("grant", grant, 1'h1);
		check("dma_chan", dma_ch, 4'h6);
		check("dma_no_ack", ack, 1'h0);
		dma <= 11'h000;
		rd(8'h00);
		check("cpl_kept", v, 8'h23);
		$display("t_dma done");
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_levels();
		t_chain();
		t_legacy();
		t_ext();
		t_top();
		t_dma();
		complete_run();
	end
endmodule
